// [verilog/gpp_params.svh]
/*
  Offsets, field positions and reset values of the three-pin port.
  Assumes inclusion by bare name from the port's design files.
*/
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH

`define GPP_OFF_PULL_DIR 8'h20
`define GPP_OFF_ALT_ROUTE 8'h24
`define GPP_OFF_PIN_DATA 8'h28

`define GPP_PULL_LSB 4
`define GPP_DIR_LSB 0
`define GPP_SEL_BIT 3
`define GPP_PEN_BIT 2
`define GPP_MODE_LSB 0

`define GPP_PULL_DIR_MASK 8'h77
`define GPP_ALT_ROUTE_MASK 8'h0f
`define GPP_PIN_DATA_MASK 8'h07
`define GPP_RESET_VALUE 8'h00

`define GPP_RESP_OKAY 2'b00
`define GPP_RESP_SLVERR 2'b10

`endif

// [verilog/gpp_pkg.sv]
/*
  Types of the three-pin port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gpp_pkg;
  typedef enum logic [1:0] {
    gpp_mode_internal = 2'b00,
    gpp_mode_serial_ext = 2'b01,
    gpp_mode_lin_ext = 2'b10,
    gpp_mode_observe = 2'b11
  } gpp_serial_mode_t;

  typedef enum logic [2:0] {
    gpp_wr_idle = 3'b001,
    gpp_wr_resp = 3'b010,
    gpp_wr_unused = 3'b100
  } gpp_wr_state_t;
endpackage : gpp_pkg

// [verilog/gpp_pin_mux.sv]
/*
  Per-pin priority driver for the three-pin port.
  Assumes all select and data inputs are on the system clock.
*/
`timescale 1ns/1ps
module gpp_pin_mux (
  // Analog claim
  input wire logic analog_sel,
  // Timer channel
  input wire logic timer_sel,
  input wire logic timer_out,
  input wire logic timer_oe,
  // Serial or pulse alternate
  input wire logic alt_sel,
  input wire logic alt_out,
  input wire logic alt_oe,
  // Plain port
  input wire logic port_dir,
  input wire logic port_data,
  input wire logic port_pullup,
  // Pad side
  output logic pad_out,
  output logic pad_oe_n,
  output logic pad_pullup,
  output logic pad_analog
);
  logic drive;

  always_comb begin
    pad_out = 1'b0;
    drive = 1'b0;
    pad_analog = 1'b0;
    if (analog_sel) begin
      pad_analog = 1'b1;
    end else if (timer_sel) begin
      pad_out = timer_out;
      drive = timer_oe;
    end else if (alt_sel) begin
      pad_out = alt_out;
      drive = alt_oe;
    end else begin
      pad_out = port_data;
      drive = port_dir;
    end
  end

  assign pad_oe_n = ~drive;
  // Pull-up while the pin is undriven and not claimed by the analog converter, whichever user selects it
  assign pad_pullup = port_pullup & ~drive & ~analog_sel;
endmodule : gpp_pin_mux

// [verilog/gpp_port.sv]
/*
  Three-pin general purpose port with function mux and AXI4-Lite registers.
  Assumes one clock domain; pins and peripheral signals enter here.
*/
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_port (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [2:0] port_pin_in,
  output logic [2:0] port_pin_out,
  output logic [2:0] port_pin_oe_n,
  output logic [2:0] port_pin_pullup,
  output logic [2:0] port_pin_analog,
  // Analog converter claims
  input wire logic [2:0] analog_channel_sel,
  // Timer channels
  input wire logic [2:0] timer_channel_sel,
  input wire logic [2:0] timer_channel_out,
  input wire logic [2:0] timer_channel_oe,
  output logic [2:0] timer_channel_in,
  // Serial controller
  input wire logic serial_txd,
  output logic serial_rxd,
  // LIN physical layer
  input wire logic lin_rxd,
  output logic lin_txd,
  // Pulse channels
  input wire logic [1:0] pulse_channel
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [2:0] pin_pullup_enable_q;
  logic [2:0] pin_direction_q;
  logic pulse_channel_select_q;
  logic pulse_output_enable_q;
  gpp_pkg::gpp_serial_mode_t serial_route_mode_q;
  logic [2:0] port_pin_data_q;
  logic [2:0] pin_sync1_q;
  logic [2:0] pin_sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  // Pins are asynchronous, so nothing but the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync1_q <= 3'h0;
      pin_sync2_q <= 3'h0;
    end else begin
      pin_sync1_q <= port_pin_in;
      pin_sync2_q <= pin_sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data may come in either order
  gpp_pkg::gpp_wr_state_t wr_state_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign s_axi_awready = (wr_state_q == gpp_pkg::gpp_wr_idle) && !aw_held_q;
  assign s_axi_wready = (wr_state_q == gpp_pkg::gpp_wr_idle) && !w_held_q;
  assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  assign wr_fire = (wr_state_q == gpp_pkg::gpp_wr_idle) && (aw_held_q || s_axi_awvalid)
    && (w_held_q || s_axi_wvalid);

  ////////////////////////////////////////////////////////////////////////////
  // Write address decode
  logic wr_hit;
  logic wr_pull_dir;
  logic wr_alt_route;
  logic wr_pin_data;

  always_comb begin
    wr_pull_dir = 1'b0;
    wr_alt_route = 1'b0;
    wr_pin_data = 1'b0;
    case (wr_addr)
      `GPP_OFF_PULL_DIR: begin
        wr_pull_dir = 1'b1;
      end
      `GPP_OFF_ALT_ROUTE: begin
        wr_alt_route = 1'b1;
      end
      `GPP_OFF_PIN_DATA: begin
        wr_pin_data = 1'b1;
      end
      default: begin
        wr_pull_dir = 1'b0;
      end
    endcase
  end

  assign wr_hit = wr_pull_dir | wr_alt_route | wr_pin_data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= gpp_pkg::gpp_wr_idle;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bresp_q <= `GPP_RESP_OKAY;
    end else begin
      case (wr_state_q)
        gpp_pkg::gpp_wr_idle: begin
          if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            wr_state_q <= gpp_pkg::gpp_wr_resp;
            // Unmapped writes still answer, so a stray address cannot stall the bus
            bresp_q <= wr_hit ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
          end else begin
            if (s_axi_awvalid && !aw_held_q) begin
              aw_held_q <= 1'b1;
              aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_q) begin
              w_held_q <= 1'b1;
              w_data_q <= s_axi_wdata;
              w_strb_q <= s_axi_wstrb;
            end
          end
        end
        gpp_pkg::gpp_wr_resp: begin
          if (s_axi_bready) begin
            wr_state_q <= gpp_pkg::gpp_wr_idle;
          end
        end
        default: begin
          wr_state_q <= gpp_pkg::gpp_wr_idle;
        end
      endcase
    end
  end

  assign s_axi_bvalid = (wr_state_q == gpp_pkg::gpp_wr_resp);
  assign s_axi_bresp = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; only byte lane 0 holds bits, others ignored
  logic wr_lane0;
  assign wr_lane0 = wr_fire && wr_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_pullup_enable_q <= 3'h0;
      pin_direction_q <= 3'h0;
    end else if (wr_lane0 && wr_pull_dir) begin
      pin_pullup_enable_q <= wr_data[`GPP_PULL_LSB +: 3];
      pin_direction_q <= wr_data[`GPP_DIR_LSB +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_channel_select_q <= 1'b0;
      pulse_output_enable_q <= 1'b0;
      serial_route_mode_q <= gpp_pkg::gpp_mode_internal;
    end else if (wr_lane0 && wr_alt_route) begin
      pulse_channel_select_q <= wr_data[`GPP_SEL_BIT];
      pulse_output_enable_q <= wr_data[`GPP_PEN_BIT];
      serial_route_mode_q <= gpp_pkg::gpp_serial_mode_t'(wr_data[`GPP_MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_pin_data_q <= 3'h0;
    end else if (wr_lane0 && wr_pin_data) begin
      port_pin_data_q <= wr_data[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel, answer one cycle after the address is taken
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_word = `GPP_RESET_VALUE;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `GPP_OFF_PULL_DIR: begin
        // Bits 7 and 3 stay zero
        rd_word = {1'b0, pin_pullup_enable_q, 1'b0, pin_direction_q};
      end
      `GPP_OFF_ALT_ROUTE: begin
        rd_word = {4'h0, pulse_channel_select_q, pulse_output_enable_q, serial_route_mode_q};
      end
      `GPP_OFF_PIN_DATA: begin
        rd_word = {5'h00, (pin_direction_q & port_pin_data_q) | (~pin_direction_q & pin_sync2_q)};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // One read in flight; the latched word holds while rvalid waits
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `GPP_RESP_OKAY;
    end else if (!rvalid_q && s_axi_arvalid) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_word};
      rresp_q <= rd_hit ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial routing
  logic serial_on_pins;
  logic alt_tx;
  logic observe;

  // Mode 01 exposes the controller, mode 10 the LIN layer
  assign serial_on_pins = (serial_route_mode_q == gpp_pkg::gpp_mode_serial_ext)
    || (serial_route_mode_q == gpp_pkg::gpp_mode_lin_ext);
  assign observe = (serial_route_mode_q == gpp_pkg::gpp_mode_observe);
  assign alt_tx = (serial_route_mode_q == gpp_pkg::gpp_mode_lin_ext) ? lin_rxd : serial_txd;

  always_comb begin
    case (serial_route_mode_q)
      gpp_pkg::gpp_mode_serial_ext: begin
        serial_rxd = pin_sync2_q[0];
        lin_txd = 1'b1;
      end
      gpp_pkg::gpp_mode_lin_ext: begin
        serial_rxd = 1'b1;
        // Pin zero is the receive side in both external modes
        lin_txd = pin_sync2_q[0];
      end
      default: begin
        serial_rxd = lin_rxd;
        lin_txd = serial_txd;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin alternate requests
  logic [2:0] alt_sel;
  logic [2:0] alt_out;
  logic [2:0] alt_oe;
  logic pulse_sel;

  assign pulse_sel = pulse_channel_select_q ? pulse_channel[1] : pulse_channel[0];

  always_comb begin
    alt_sel = 3'h0;
    alt_out = 3'h0;
    alt_oe = 3'h0;
    if (serial_on_pins) begin
      // Pin 0 receives in external modes; mode 10 drives LIN rx out on pin 1
      alt_sel[0] = 1'b1;
      alt_sel[1] = 1'b1;
      alt_out[1] = alt_tx;
      alt_oe[1] = 1'b1;
    end else if (observe) begin
      // Observe mode mirrors the internal join onto both pins
      alt_sel[1:0] = 2'h3;
      alt_out[0] = lin_rxd;
      alt_out[1] = serial_txd;
      alt_oe[1:0] = 2'h3;
    end
    // Pulse disabled hands pin two back to plain I/O
    alt_sel[2] = pulse_output_enable_q;
    alt_out[2] = pulse_sel;
    alt_oe[2] = pulse_output_enable_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      gpp_pin_mux u_mux (
        .analog_sel(analog_channel_sel[gi]),
        .timer_sel(timer_channel_sel[gi]),
        .timer_out(timer_channel_out[gi]),
        .timer_oe(timer_channel_oe[gi]),
        .alt_sel(alt_sel[gi]),
        .alt_out(alt_out[gi]),
        .alt_oe(alt_oe[gi]),
        .port_dir(pin_direction_q[gi]),
        .port_data(port_pin_data_q[gi]),
        .port_pullup(pin_pullup_enable_q[gi]),
        .pad_out(port_pin_out[gi]),
        .pad_oe_n(port_pin_oe_n[gi]),
        .pad_pullup(port_pin_pullup[gi]),
        .pad_analog(port_pin_analog[gi])
      );
    end
  endgenerate

  // Timer capture sees the synchronised pin
  assign timer_channel_in = pin_sync2_q;
endmodule : gpp_port

// [tb/gpp_pin_far.sv]
/*
  Far side of the three pins: board drive, pull-ups and floating lines.
  Assumes the port's pad outputs and the one system clock.
*/
`timescale 1ns/1ps
module gpp_pin_far (
  // Clock
  input wire logic aclk,
  // Pad side of the port
  input wire logic [2:0] drv_out,
  input wire logic [2:0] drv_oe_n,
  input wire logic [2:0] pull,
  // Board drive per pin
  input wire logic [2:0] ext_val,
  input wire logic [2:0] ext_en,
  // Wire level seen by the port
  output logic [2:0] level
);
  // Floating lines wander so a settled unknown never passes for data
  logic [2:0] float_q = 3'b010;
  always_ff @(posedge aclk) float_q <= ~float_q;
  // Port drive wins over the board; a pull-up only lifts an undriven line
  assign level = (~drv_oe_n & drv_out) | (drv_oe_n & ext_en & ext_val) | (drv_oe_n & ~ext_en & (pull | float_q));
endmodule : gpp_pin_far

// [tb/gpp_port_asserts.sv]
/*
  Checker for the port's pads and register bus.
  Assumes a bind onto gpp_port, one clock, synchronous reset.
*/
`timescale 1ns/1ps
module gpp_port_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and peripherals
  input wire logic [2:0] port_pin_in,
  input wire logic [2:0] port_pin_out,
  input wire logic [2:0] port_pin_oe_n,
  input wire logic [2:0] port_pin_pullup,
  input wire logic [2:0] port_pin_analog,
  input wire logic [2:0] analog_channel_sel,
  input wire logic [2:0] timer_channel_sel,
  input wire logic [2:0] timer_channel_out,
  input wire logic [2:0] timer_channel_oe,
  input wire logic [2:0] timer_channel_in
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] tm;
  assign tm = timer_channel_sel & ~analog_channel_sel;
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_analog_claim: assert property (port_pin_analog == analog_channel_sel &&
    (port_pin_oe_n & analog_channel_sel) == analog_channel_sel && (port_pin_pullup & analog_channel_sel) == 3'h0)
    else $error("analog claim not honoured");
  a_timer_drive: assert property ((~port_pin_oe_n & tm) == (timer_channel_oe & tm) &&
    ((port_pin_out ^ timer_channel_out) & tm & timer_channel_oe) == 3'h0) else $error("timer drive wrong");
  a_pull_off_out: assert property ((port_pin_pullup & ~port_pin_oe_n) == 3'h0)
    else $error("pull-up on a driven pin");
  a_sync_two: assert property ($past(aresetn) && $past(aresetn, 2) |->
    timer_channel_in == $past(port_pin_in, 2)) else $error("pin sync latency wrong");
  a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid) else $error("write not answered");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid && s_axi_rdata[31:7] == 25'h0)
    else $error("read answer wrong");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : gpp_port_asserts
bind gpp_port gpp_port_asserts chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .port_pin_in, .port_pin_out, .port_pin_oe_n, .port_pin_pullup, .port_pin_analog,
  .analog_channel_sel, .timer_channel_sel, .timer_channel_out, .timer_channel_oe, .timer_channel_in);

// [tb/tb_gpp_port.sv]
/*
  Self-checking bench: AXI4-Lite master tasks and random pin traffic.
  Assumes the partner model and the checker bind are compiled with it.
*/
`timescale 1ns/1ps
`include "gpp_params.svh"
module tb_gpp_port;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pd = 8'h00, ar = 8'h00, dt = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [2:0] an = 3'h0, tsel = 3'h0, tout = 3'h0, toe = 3'h0, ext_val = 3'h0, ext_en = 3'h7;
  logic [1:0] pulse = 2'h0, bresp, rresp, rs;
  logic [3:0] wstrb = 4'hf;
  logic stx = 1'b1, lrx = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, srx, ltx;
  logic [2:0] pin_in, pin_out, oe_n, pull, pin_an, tin;
  int failures = 0, n_checks = 0;
  integer seed = 32'hd8f06cc0;
  gpp_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe_n(oe_n), .port_pin_pullup(pull),
    .port_pin_analog(pin_an), .analog_channel_sel(an), .timer_channel_sel(tsel), .timer_channel_out(tout),
    .timer_channel_oe(toe), .timer_channel_in(tin), .serial_txd(stx), .serial_rxd(srx), .lin_rxd(lrx),
    .lin_txd(ltx), .pulse_channel(pulse));
  gpp_pin_far far_u (.aclk(aclk), .drv_out(pin_out), .drv_oe_n(oe_n), .pull(pull), .ext_val(ext_val),
    .ext_en(ext_en), .level(pin_in));
  always #50 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Each channel is released on the edge that takes it
    do begin
      @(posedge aclk);
      ta |= (awready === 1'b1);
      tw |= (wready === 1'b1);
      awvalid <= !ta;
      wvalid <= !tw;
    end while (!(ta && tw));
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask : rd_reg
  ////////////////////////////////////////
  // Expected pad as {oe_n, out, pull, pull checked}
  function automatic logic [3:0] exp_pin(input int i);
    if (an[i]) return 4'b1001;
    if (tsel[i]) return {~toe[i], tout[i], 2'b00};
    if (i == 0 && ar[1:0] != 2'b00) return ar[1:0] == 2'b11 ? {1'b0, lrx, 2'b00} : 4'b1000;
    if (i == 1 && ar[1:0] != 2'b00) return {1'b0, ar[1:0] == 2'b10 ? lrx : stx, 2'b00};
    if (i == 2 && ar[2]) return {1'b0, pulse[ar[3]], 2'b00};
    return {~pd[i], dt[i], pd[i + 4] & ~pd[i], 1'b1};
  endfunction : exp_pin
  // Valid only while the board drives every undriven line
  function automatic logic lvl(input int i);
    logic [3:0] e;
    e = exp_pin(i);
    return e[3] ? ext_val[i] : e[2];
  endfunction : lvl
  task automatic chk_pins();
    logic [3:0] e;
    logic [2:0] d;
    logic sj;
    sj = ar[1] == ar[0];
    for (int i = 0; i < 3; i++) begin
      e = exp_pin(i);
      chk("pin_oe_n", e[3], oe_n[i]);
      if (!e[3]) chk("pin_out", e[2], pin_out[i]);
      if (e[0]) chk("pin_pullup", e[1], pull[i]);
      d[i] = pd[i] ? dt[i] : lvl(i);
    end
    chk("pin_analog", an, pin_an);
    chk("timer_in", {lvl(2), lvl(1), lvl(0)}, tin);
    chk("serial_rxd", sj ? lrx : ar[1:0] == 2'b01 ? lvl(0) : 1'b1, srx);
    chk("lin_txd", sj ? stx : ar[1:0] == 2'b10 ? lvl(0) : 1'b1, ltx);
    rd_reg(`GPP_OFF_PIN_DATA);
    chk("pin_data", d & ~an, rd & {29'h0, ~an});
  endtask : chk_pins
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    test_done();
  end
  initial begin
    logic [31:0] v, w;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(`GPP_OFF_PULL_DIR);
    chk("pull_dir_reset", 32'h0, rd);
    rd_reg(`GPP_OFF_ALT_ROUTE);
    chk("alt_route_reset", 32'h0, rd);
    chk_pins();
    rd_reg(8'h2c);
    chk("unmapped_read", 2'b10, rs);
    wr(8'h30, 32'hff);
    chk("unmapped_write", 2'b10, rs);
    // Early rounds keep analog and timer off so lower users are reached
    for (int k = 0; k < 40; k++) begin
      v = $random(seed);
      w = $random(seed);
      {ext_val, stx, lrx, pulse, toe, tout} <= v[12:0];
      tsel <= k < 8 ? 3'h0 : v[15:13];
      an <= k < 16 ? 3'h0 : v[18:16] & v[21:19];
      wr(`GPP_OFF_PULL_DIR, {24'h0, v[29:22]});
      pd = v[29:22] & 8'h77;
      wr(`GPP_OFF_ALT_ROUTE, {24'h0, w[7:2], 2'(k)});
      ar = {w[7:2], 2'(k)} & 8'h0f;
      wr(`GPP_OFF_PIN_DATA, {24'h0, w[15:8]});
      dt = w[15:8] & 8'h07;
      chk("wr_resp", 2'b00, rs);
      rd_reg(`GPP_OFF_PULL_DIR);
      chk("pull_dir", pd, rd);
      rd_reg(`GPP_OFF_ALT_ROUTE);
      chk("alt_route", ar, rd);
      chk_pins();
    end
    an <= 3'h0;
    tsel <= 3'h0;
    ext_en <= 3'h0;
    wr(`GPP_OFF_ALT_ROUTE, 32'h0);
    wr(`GPP_OFF_PULL_DIR, 32'h70);
    repeat (3) @(posedge aclk);
    chk("pullup_on", 3'h7, pull);
    rd_reg(`GPP_OFF_PIN_DATA);
    chk("pulled_high", 32'h7, rd);
    // Lane zero off: the data write must leave dt in place
    wstrb <= 4'he;
    wr(`GPP_OFF_PIN_DATA, {29'h0, ~dt[2:0]});
    chk("strb_okay", 2'b00, rs);
    wstrb <= 4'hf;
    wr(`GPP_OFF_PULL_DIR, 32'h77);
    chk("pullup_out", 3'h0, pull);
    rd_reg(`GPP_OFF_PIN_DATA);
    chk("out_data", dt, rd);
    test_done();
  end
endmodule : tb_gpp_port
